/* File: rtl/sf_read_defs.vh */
// Constants shared by the continuous array read path and its prefetch FIFO.
`ifndef SF_READ_DEFS_VH
`define SF_READ_DEFS_VH

// Opcodes of the four continuous main-array reads.
`define OP_READ_LEGACY   8'he8
`define OP_READ_FASTEST  8'h1b
`define OP_READ_FAST     8'h0b
`define OP_READ_SLOW     8'h03

// Dummy bytes that follow the three address bytes for each opcode.
`define DUMMY_LEGACY     3'h4
`define DUMMY_FASTEST    3'h2
`define DUMMY_FAST       3'h1
`define DUMMY_SLOW       3'h0

// Address layout.
`define PAGE_W           12
`define BYTE_W           10
`define LAST_ADDR_BYTE   2'h2
`define LAST_BYTE_LONG   10'h20f
`define LAST_BYTE_DEF    10'h1ff

// Prefetch buffer shape.
`define FIFO_WIDTH       8
`define FIFO_DEPTH       32
`define FIFO_AW          5

`endif

/* File: rtl/stream_fifo.v */
// Synchronous FIFO with valid/ready on both sides and a flush.
`timescale 1ns/1ps
module stream_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  localparam [AW:0]   FULL_CNT = DEPTH;
  localparam [AW-1:0] PTR_ONE  = 1;
  localparam [AW:0]   CNT_ONE  = 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];

  // Storage is not reset; only pointers and the count carry meaning.
  always @(posedge clk) begin
    if (ce && push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (flush) begin
        wr_q  <= {AW{1'b0}};
        rd_q  <= {AW{1'b0}};
        cnt_q <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          wr_q <= wr_q + PTR_ONE;
        end
        if (pop) begin
          rd_q <= rd_q + PTR_ONE;
        end
        if (push && !pop) begin
          cnt_q <= cnt_q + CNT_ONE;
        end else if (pop && !push) begin
          cnt_q <= cnt_q - CNT_ONE;
        end
      end
    end
  end

endmodule // stream_fifo

/* File: rtl/serial_flash_continuous_array_read.v */
// Continuous main-array read path of a serial flash, oversampled on mclk.
`timescale 1ns/1ps
`include "sf_read_defs.vh"
module serial_flash_continuous_array_read (
  input  wire                 mclk,
  input  wire                 rst_n,
  input  wire                 ce,
  input  wire                 cs_n_pin,
  input  wire                 sck_pin,
  input  wire                 si_pin,
  input  wire                 page_528,
  output reg                  so_q,
  output reg                  so_oe_q,
  output reg                  underrun_q,
  output reg                  arr_req_q,
  output reg  [`PAGE_W-1:0]   arr_page_q,
  output reg  [`BYTE_W-1:0]   arr_byte_q,
  input  wire                 arr_ack,
  input  wire [7:0]           arr_rdata
);

  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_OPC   = 6'h02;
  localparam [5:0] ST_ADDR  = 6'h04;
  localparam [5:0] ST_DUMMY = 6'h08;
  localparam [5:0] ST_DATA  = 6'h10;
  localparam [5:0] ST_SKIP  = 6'h20;

  // Pin synchronisers; stage 0 feeds only stage 1, stage 2 serves edge detection.
  reg [2:0] cs_s_q;
  reg [2:0] sck_s_q;
  reg [1:0] si_s_q;

  always @(posedge mclk) begin
    if (!rst_n) begin
      cs_s_q  <= 3'h7;
      sck_s_q <= 3'h0;
      si_s_q  <= 2'h0;
    end else if (ce) begin
      cs_s_q  <= {cs_s_q[1:0], cs_n_pin};
      sck_s_q <= {sck_s_q[1:0], sck_pin};
      si_s_q  <= {si_s_q[0], si_pin};
    end
  end

  wire cs_n     = cs_s_q[1];
  wire cs_rise  = cs_s_q[1] & ~cs_s_q[2];
  wire sck_rise = sck_s_q[1] & ~sck_s_q[2];
  wire sck_fall = ~sck_s_q[1] & sck_s_q[2];
  wire si       = si_s_q[1];

  // Opcode decode: bit 3 marks a supported read, bits 2:0 its dummy byte count.
  function [3:0] op_info;
    input [7:0] op;
    begin
      case (op)
        `OP_READ_LEGACY:  op_info = {1'b1, `DUMMY_LEGACY};
        `OP_READ_FASTEST: op_info = {1'b1, `DUMMY_FASTEST};
        `OP_READ_FAST:    op_info = {1'b1, `DUMMY_FAST};
        `OP_READ_SLOW:    op_info = {1'b1, `DUMMY_SLOW};
        default:          op_info = 4'h0;
      endcase
    end
  endfunction

  reg [5:0]  state_q;
  reg [2:0]  bit_cnt_q;
  reg [6:0]  in_sh_q;
  reg [15:0] addr_hi_q;
  reg [1:0]  addr_cnt_q;
  reg [2:0]  dummy_q;

  wire [7:0]  rx_byte   = {in_sh_q, si};
  wire        byte_done = sck_rise & (bit_cnt_q == 3'h7);
  wire [3:0]  rx_info   = op_info(rx_byte);
  wire [23:0] full_addr = {addr_hi_q, rx_byte};
  wire        addr_load = byte_done & (state_q == ST_ADDR) & (addr_cnt_q == `LAST_ADDR_BYTE);

  // Command sequencer; every bit is taken on a rising SCK edge.
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= 3'h0;
      in_sh_q    <= 7'h00;
      addr_hi_q  <= 16'h0000;
      addr_cnt_q <= 2'h0;
      dummy_q    <= 3'h0;
    end else if (ce) begin
      if (cs_n) begin
        state_q    <= ST_IDLE;
        bit_cnt_q  <= 3'h0;
        addr_cnt_q <= 2'h0;
      end else begin
        if (state_q == ST_IDLE) begin
          state_q <= ST_OPC;
        end
        if (sck_rise) begin
          in_sh_q   <= {in_sh_q[5:0], si};
          bit_cnt_q <= bit_cnt_q + 3'h1;
        end
        if (byte_done) begin
          case (state_q)
            ST_OPC: begin
              dummy_q <= rx_info[2:0];
              if (rx_info[3]) begin
                state_q <= ST_ADDR;
              end else begin
                state_q <= ST_SKIP;
              end
            end
            ST_ADDR: begin
              addr_hi_q  <= {addr_hi_q[7:0], rx_byte};
              addr_cnt_q <= addr_cnt_q + 2'h1;
              if (addr_cnt_q == `LAST_ADDR_BYTE) begin
                if (dummy_q == 3'h0) begin
                  state_q <= ST_DATA;
                end else begin
                  state_q <= ST_DUMMY;
                end
              end
            end
            ST_DUMMY: begin
              dummy_q <= dummy_q - 3'h1;
              if (dummy_q == 3'h1) begin
                state_q <= ST_DATA;
              end
            end
            default: begin
              state_q <= state_q;
            end
          endcase
        end
      end
    end
  end

  // Start address split by page size.
  wire [`PAGE_W-1:0] ld_page = page_528 ? full_addr[21:10] : full_addr[20:9];
  wire [`BYTE_W-1:0] ld_byte = page_528 ? full_addr[9:0]
                                        : {1'b0, full_addr[8:0]};

  // Next fetch address: byte steps inside a page, then the page steps and wraps.
  wire [`BYTE_W-1:0] last_byte = page_528 ? `LAST_BYTE_LONG : `LAST_BYTE_DEF;
  wire               page_end  = (arr_byte_q == last_byte);
  wire [`BYTE_W-1:0] nxt_byte  = page_end ? {`BYTE_W{1'b0}}
                                          : arr_byte_q + {{(`BYTE_W-1){1'b0}}, 1'b1};
  wire [`PAGE_W-1:0] nxt_page  = page_end ? arr_page_q + {{(`PAGE_W-1){1'b0}}, 1'b1}
                                          : arr_page_q;

  reg  run_q;
  reg  stale_q;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_dout;
  wire fetch_done = arr_req_q & arr_ack;
  wire push       = fetch_done & ~stale_q & run_q;

  // Prefetcher. The counter advances per byte fetched, which keeps the
  // serial stream gapless while the FIFO absorbs array latency.
  // This path has no write port toward the SRAM buffers at all.
  always @(posedge mclk) begin
    if (!rst_n) begin
      run_q      <= 1'b0;
      stale_q    <= 1'b0;
      arr_req_q  <= 1'b0;
      arr_page_q <= {`PAGE_W{1'b0}};
      arr_byte_q <= {`BYTE_W{1'b0}};
    end else if (ce) begin
      if (fetch_done) begin
        arr_req_q <= 1'b0;
        stale_q   <= 1'b0;
      end else if (run_q && !arr_req_q && fifo_in_ready && !cs_n) begin
        arr_req_q <= 1'b1;
      end
      // A fetch still open when the frame ends belongs to no command.
      if (cs_rise) begin
        run_q <= 1'b0;
        if (arr_req_q && !arr_ack) begin
          stale_q <= 1'b1;
        end
      end
      if (addr_load) begin
        run_q      <= 1'b1;
        arr_page_q <= ld_page;
        arr_byte_q <= ld_byte;
      end else if (push) begin
        arr_page_q <= nxt_page;
        arr_byte_q <= nxt_byte;
      end
    end
  end

  reg  [2:0] out_cnt_q;
  reg  [7:0] out_sh_q;
  wire       data_edge = sck_fall & ~cs_n & (state_q == ST_DATA);
  wire       pop       = data_edge & (out_cnt_q == 3'h0) & fifo_out_valid;

  stream_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_prefetch (
    .clk       (mclk),
    .rst_n     (rst_n),
    .ce        (ce),
    .flush     (cs_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (arr_rdata),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_dout)
  );

  // Serialiser: SO changes only after falling SCK edges of the data phase.
  // An empty FIFO at a byte boundary sends zeros and raises the underrun
  // flag; the flag clears when the next frame opens.
  always @(posedge mclk) begin
    if (!rst_n) begin
      so_q       <= 1'b0;
      so_oe_q    <= 1'b0;
      underrun_q <= 1'b0;
      out_cnt_q  <= 3'h0;
      out_sh_q   <= 8'h00;
    end else if (ce) begin
      if (cs_n) begin
        so_oe_q   <= 1'b0;
        out_cnt_q <= 3'h0;
      end else begin
        if (state_q == ST_IDLE) begin
          underrun_q <= 1'b0;
        end
        if (data_edge) begin
          so_oe_q   <= 1'b1;
          out_cnt_q <= out_cnt_q + 3'h1;
          if (out_cnt_q == 3'h0) begin
            if (fifo_out_valid) begin
              so_q     <= fifo_dout[7];
              out_sh_q <= {fifo_dout[6:0], 1'b0};
            end else begin
              so_q       <= 1'b0;
              out_sh_q   <= 8'h00;
              underrun_q <= 1'b1;
            end
          end else begin
            so_q     <= out_sh_q[7];
            out_sh_q <= {out_sh_q[6:0], 1'b0};
          end
        end
      end
    end
  end

endmodule // serial_flash_continuous_array_read

/* File: bench/sf_read_checker.sv */
// Assertion checker for the continuous array read path.
`timescale 1ns/1ps
`include "sf_read_defs.vh"
module sf_read_checker (
  input wire               mclk,
  input wire               rst_n,
  input wire               ce,
  input wire               cs_n_pin,
  input wire               sck_pin,
  input wire               si_pin,
  input wire               page_528,
  input wire               so_q,
  input wire               so_oe_q,
  input wire               underrun_q,
  input wire               arr_req_q,
  input wire [`PAGE_W-1:0] arr_page_q,
  input wire [`BYTE_W-1:0] arr_byte_q,
  input wire               arr_ack,
  input wire [7:0]         arr_rdata
);
  reg  [4:0] sck_h;
  reg        req_d = 1'b0;
  reg        live = 1'b0;
  wire       last_b = arr_byte_q == (page_528 ? 10'h20f : 10'h1ff);
  // The window spans the synchroniser delay between a pin fall and the output change.
  wire       recent_fall = |(~sck_h[3:0] & sck_h[4:1]);
  always @(posedge mclk) sck_h <= {sck_h[3:0], sck_pin};
  // Only a request raised inside the open frame moves the counter; one left
  // over from an earlier frame is answered but its byte is dropped.
  always @(posedge mclk) begin
    req_d <= arr_req_q;
    if (!rst_n || cs_n_pin) begin
      live <= 1'b0;
    end else if (arr_req_q && !req_d) begin
      live <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property (
    rst_n && !$past(rst_n) |-> !so_oe_q && !arr_req_q && !underrun_q)
    else $error("Outputs busy after reset.");
  a_ack_drops_req: assert property (arr_req_q && arr_ack |=> !arr_req_q)
    else $error("Request kept after ack.");
  a_req_holds: assert property (arr_req_q && !arr_ack |=> arr_req_q)
    else $error("Request dropped early.");
  a_byte_steps: assert property (
    arr_req_q && arr_ack && live && !last_b |=> arr_byte_q == $past(arr_byte_q) + 10'h1)
    else $error("Byte counter did not step.");
  a_page_steps: assert property (
    arr_req_q && arr_ack && live && last_b
    |=> arr_byte_q == 10'h0 && arr_page_q == $past(arr_page_q) + 12'h1)
    else $error("Page did not step.");
  a_oe_off_cs: assert property ($rose(cs_n_pin) |-> ##[3:5] !so_oe_q)
    else $error("Output still driven after deselect.");
  a_oe_idle: assert property (cs_n_pin [*6] |-> !so_oe_q)
    else $error("Output driven while deselected.");
  a_so_on_fall: assert property (
    so_oe_q && $past(so_oe_q) && $changed(so_q) |-> recent_fall)
    else $error("Output changed without clock fall.");
endmodule // sf_read_checker
bind serial_flash_continuous_array_read sf_read_checker u_chk (.mclk(mclk), .rst_n(rst_n),
  .ce(ce), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin), .page_528(page_528),
  .so_q(so_q), .so_oe_q(so_oe_q), .underrun_q(underrun_q), .arr_req_q(arr_req_q),
  .arr_page_q(arr_page_q), .arr_byte_q(arr_byte_q), .arr_ack(arr_ack),
  .arr_rdata(arr_rdata));

/* File: bench/array_model.sv */
// Behavioural main array answering one byte per request.
`timescale 1ns/1ps
`include "sf_read_defs.vh"
module array_model (
  input  wire               mclk,
  input  wire [3:0]         lat,
  input  wire               arr_req_q,
  input  wire [`PAGE_W-1:0] arr_page_q,
  input  wire [`BYTE_W-1:0] arr_byte_q,
  output reg                arr_ack = 1'h0,
  output reg  [7:0]         arr_rdata = 8'h0
);
  reg [3:0] cnt = 4'h0;
  // Data toggles between answers so a stale byte cannot pass as fresh.
  always @(posedge mclk) begin
    arr_ack <= 1'h0;
    arr_rdata <= ~arr_rdata;
    cnt <= 4'h0;
    if (arr_req_q && !arr_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat) begin
        arr_ack <= 1'h1;
        arr_rdata <= arr_byte_q[7:0] ^ {arr_page_q[3:0], 4'h0};
      end
    end
  end
endmodule // array_model

/* File: bench/serial_flash_continuous_array_read_bench.sv */
// Self-checking bench for the continuous array read path.
`timescale 1ns/1ps
`include "sf_read_defs.vh"
module serial_flash_continuous_array_read_bench;
  reg                mclk = 1'h0;
  reg                rst_n = 1'h0;
  reg                cs_n = 1'h1;
  reg                sck = 1'h0;
  reg                si = 1'h0;
  reg                p528 = 1'h0;
  reg                got = 1'h1;
  reg  [3:0]         lat = 4'h1;
  reg  [7:0]         rx;
  reg  [11:0]        ep, fp;
  reg  [9:0]         eb, fb;
  wire               so, oe, ack, req, unr;
  wire [`PAGE_W-1:0] pg;
  wire [`BYTE_W-1:0] by;
  wire [7:0]         rd;
  integer            n_mismatch = 0;
  integer            checks = 0;
  initial forever #5 mclk = ~mclk;
  serial_flash_continuous_array_read dut (.mclk(mclk), .rst_n(rst_n), .ce(1'h1),
    .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si), .page_528(p528), .so_q(so),
    .so_oe_q(oe), .underrun_q(unr), .arr_req_q(req), .arr_page_q(pg), .arr_byte_q(by),
    .arr_ack(ack), .arr_rdata(rd));
  array_model u_arr (.mclk(mclk), .lat(lat), .arr_req_q(req), .arr_page_q(pg),
    .arr_byte_q(by), .arr_ack(ack), .arr_rdata(rd));
  always @(posedge mclk) if (req && !got) begin
    fp <= pg;
    fb <= by;
    got <= 1'h1;
  end
  task tick(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task xfer(input [7:0] tx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        si = tx[i];
        tick(16);
        sck = 1'h1;
        rx[i] = so;
        tick(16);
        sck = 1'h0;
      end
    end
  endtask
  task frame(input [7:0] op, input [2:0] nd, input [23:0] a, input [2:0] nb);
    integer k;
    reg [11:0] sp;
    reg [9:0] sb;
    begin
      sp = p528 ? a[21:10] : a[20:9];
      sb = p528 ? a[9:0] : {1'h0, a[8:0]};
      ep = sp;
      eb = sb;
      got = 1'h0;
      cs_n = 1'h0;
      tick(4);
      xfer(op);
      xfer(a[23:16]);
      xfer(a[15:8]);
      xfer(a[7:0]);
      for (k = 0; k < nd; k = k + 1) xfer(8'h00);
      if (nd > 1) chk(req, 1'h0);
      for (k = 0; k < nb; k = k + 1) begin
        xfer(8'h00);
        chk(rx, eb[7:0] ^ {ep[3:0], 4'h0});
        chk(oe, 1'h1);
        if (eb == (p528 ? 10'h20f : 10'h1ff)) begin
          eb = 10'h0;
          ep = ep + 12'h1;
        end else eb = eb + 10'h1;
      end
      cs_n = 1'h1;
      tick(8);
      chk(oe, 1'h0);
      chk(fp, sp);
      chk(fb, sb);
    end
  endtask
  task s_slow;
    begin
      p528 = 1'h0;
      frame(8'h03, 3'h0, {3'h0, 12'h005, 9'h1fe}, 3'h4);
    end
  endtask
  task s_fast;
    begin
      p528 = 1'h1;
      frame(8'h0b, 3'h1, {2'h0, 12'hfff, 10'h20e}, 3'h3);
    end
  endtask
  task s_fastest;
    begin
      p528 = 1'h0;
      lat = 4'h6;
      frame(8'h1b, 3'h2, {3'h0, 12'hfff, 9'h1ff}, 3'h2);
    end
  endtask
  task s_legacy;
    begin
      p528 = 1'h1;
      lat = 4'h1;
      frame(8'he8, 3'h4, {2'h0, 12'h007, 10'h003}, 3'h2);
    end
  endtask
  task s_bad;
    begin
      cs_n = 1'h0;
      tick(4);
      xfer(8'h9f);
      xfer(8'h00);
      chk(oe, 1'h0);
      cs_n = 1'h1;
      tick(8);
    end
  endtask
  task s_reset;
    begin
      p528 = 1'h0;
      cs_n = 1'h0;
      tick(4);
      xfer(8'h03);
      xfer(8'h00);
      xfer(8'h02);
      xfer(8'h00);
      xfer(8'h00);
      chk(oe, 1'h1);
      rst_n = 1'h0;
      tick(2);
      chk(oe, 1'h0);
      chk(req, 1'h0);
      cs_n = 1'h1;
      tick(3);
      rst_n = 1'h1;
      tick(8);
    end
  endtask
  // A slow array misses the first byte of a no-dummy read: zeros go out and
  // the sticky flag stays up until the next frame opens.
  task s_underrun;
    begin
      p528 = 1'h0;
      lat = 4'hf;
      cs_n = 1'h0;
      tick(4);
      xfer(8'h03);
      xfer(8'h00);
      xfer(8'h00);
      xfer(8'h10);
      chk(unr, 1'h0);
      xfer(8'h00);
      chk(rx, 8'h00);
      chk(unr, 1'h1);
      cs_n = 1'h1;
      tick(8);
      chk(unr, 1'h1);
      cs_n = 1'h0;
      tick(4);
      chk(unr, 1'h0);
      cs_n = 1'h1;
      tick(8);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    tick(5);
    rst_n = 1'h1;
    tick(2);
    s_slow;
    s_fast;
    s_bad;
    s_reset;
    s_underrun;
    s_fastest;
    s_legacy;
    end_sim;
  end
endmodule // serial_flash_continuous_array_read_bench
